// [rtl/sdram_ctrl.sv]
// sdram controller with an axi4-lite register port
`timescale 1ns/10ps
`default_nettype none
module sdram_ctrl import sdram_pkg::*; #(
  parameter bit extended_temperature_grade = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  sdram_if.ctrl link
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_PRE = 3'h1, ST_ACT = 3'h2, ST_COL = 3'h3,
    ST_RDW = 3'h4, ST_GAP = 3'h5, ST_REF = 3'h6, ST_LMR = 3'h7
  } state_t;
  localparam logic [10:0] REF_CYC = 11'(extended_temperature_grade ?
                                         REF_EXT_CYC : REF_STD_CYC);

  state_t state, ret, next_state, next_ret;
  logic [7:0] wcnt, next_wcnt;
  logic [10:0] rcnt;
  logic ref_due, op_pend, go, aw_h, w_h, rdv, cke_q, oe_n_q;
  logic [7:0] aw_a;
  logic [31:0] w_d, addr_r, wdata_r, ctrl_r, rdat_r;
  logic [3:0] w_s;
  op_t op_r;
  logic [BANKS-1:0] open_q;
  logic [AW-1:0] rows [BANKS];
  logic [2:0] cl_q;
  cmd_t cmd_q, next_cmd;
  logic [BW-1:0] ba_q, next_ba;
  logic [AW-1:0] addr_q, next_addr;
  logic [NBYTE-1:0] dqm_q, next_dqm;
  logic next_oe_n, cs_n_q;

  function automatic logic [31:0] merge(input logic [31:0] o,
      input logic [31:0] n, input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8+:8] = n[i*8+:8];
      end
    end
    return r;
  endfunction : merge

  wire logic busy = op_pend || state != ST_IDLE;
  wire logic [BW-1:0] bank = addr_r[BANK_LSB+:BW];
  wire logic [AW-1:0] row = addr_r[ROW_LSB+:AW];
  // row hit check against the tracked open row
  wire logic hit = open_q[bank] && rows[bank] == row;
  wire logic start = state == ST_IDLE && cke_q;
  wire logic wr_do = aw_h && w_h && !bvalid;
  wire logic ar_do = arvalid && !rvalid;
  wire logic wr_ok = aw_a == REG_CMD || aw_a == REG_ADDR ||
                     aw_a == REG_WDATA || aw_a == REG_CTRL ||
                     aw_a == REG_RDATA || aw_a == REG_STATUS;
  wire logic rd_ok = araddr == REG_CMD || araddr == REG_ADDR ||
                     araddr == REG_WDATA || araddr == REG_CTRL ||
                     araddr == REG_RDATA || araddr == REG_STATUS;
  wire logic [31:0] status = {29'h0, !cke_q, rdv, busy};
  wire logic [31:0] rd_mux =
    araddr == REG_CMD ? {29'h0, op_r} :
    araddr == REG_ADDR ? addr_r :
    araddr == REG_WDATA ? wdata_r :
    araddr == REG_RDATA ? rdat_r :
    araddr == REG_STATUS ? status :
    araddr == REG_CTRL ? ctrl_r : 32'h0;
  wire logic all_pre = ret != ST_ACT &&
                       (ret != ST_IDLE || addr_r[ALL_BIT]);
  wire logic pd_hold = ctrl_r[PD_BIT] && state == ST_IDLE &&
                       !ref_due && !op_pend;

  assign awready = !aw_h;
  assign wready = !w_h;
  assign arready = !rvalid;

  always_comb begin
    next_state = state;
    next_ret = ret;
    next_wcnt = wcnt;
    next_cmd = CMD_NOP;
    next_ba = ba_q;
    next_addr = addr_q;
    next_dqm = '0;
    next_oe_n = 1'b1;
    go = 1'b0;
    case (state)
      ST_IDLE: begin
        // pending refresh goes ahead of software orders
        if (start && ref_due) begin
          next_state = ST_PRE;
          next_ret = ST_REF;
        end else if (start && op_pend) begin
          go = 1'b1;
          case (op_r)
            OP_READ, OP_WRITE: begin
              // open the row before any column access
              next_state = hit ? ST_COL :
                           (open_q[bank] ? ST_PRE : ST_ACT);
              next_ret = ST_ACT;
            end
            OP_MODE: begin
              next_state = ST_PRE;
              next_ret = ST_LMR;
            end
            OP_PRE: begin
              next_state = ST_PRE;
              next_ret = ST_IDLE;
            end
            // burst stop for running full-row bursts
            OP_STOP: next_cmd = CMD_BST;
            default: next_cmd = CMD_NOP;
          endcase
        end
      end
      ST_PRE: begin
        next_cmd = CMD_PRE;
        next_ba = bank;
        next_addr = '0;
        next_addr[AP_BIT] = all_pre;
        next_wcnt = 8'(TRP_CYC);
        next_state = ST_GAP;
      end
      ST_ACT: begin
        // bank and row with the row-open command
        next_cmd = CMD_ACT;
        next_ba = bank;
        next_addr = row;
        next_wcnt = 8'(TRCD_CYC);
        next_ret = ST_COL;
        next_state = ST_GAP;
      end
      ST_COL: begin
        // column in low bits, no auto precharge
        next_ba = bank;
        next_addr = AW'(addr_r[CW-1:0]);
        if (op_r == OP_READ) begin
          next_cmd = CMD_RD;
          next_wcnt = 8'(cl_q);
          next_state = ST_RDW;
        end else begin
          // byte mask from the control register
          next_cmd = CMD_WR;
          next_dqm = ctrl_r[MASK_LSB+:NBYTE];
          next_oe_n = 1'b0;
          next_wcnt = 8'(TWR_CYC);
          next_ret = ST_IDLE;
          next_state = ST_GAP;
        end
      end
      ST_RDW, ST_GAP: begin
        if (wcnt != '0) begin
          next_wcnt = wcnt - 8'h01;
        end else begin
          next_state = state == ST_RDW ? ST_IDLE : ret;
        end
      end
      ST_REF: begin
        // only auto refresh is ever issued
        next_cmd = CMD_REF;
        next_wcnt = 8'(TRFC_CYC);
        next_ret = ST_IDLE;
        next_state = ST_GAP;
      end
      ST_LMR: begin
        next_cmd = CMD_LMR;
        next_addr = addr_r[AW-1:0];
        next_wcnt = 8'(TMRD_CYC);
        next_ret = ST_IDLE;
        next_state = ST_GAP;
      end
      default: next_state = ST_IDLE;
    endcase
  end

  // pins change only just after the rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_IDLE;
      ret <= ST_IDLE;
      wcnt <= '0;
      cmd_q <= CMD_NOP;
      ba_q <= '0;
      addr_q <= '0;
      dqm_q <= '1;
      oe_n_q <= 1'b1;
      cke_q <= 1'b1;
      cs_n_q <= 1'b1;
    end else begin
      state <= next_state;
      ret <= next_ret;
      wcnt <= next_wcnt;
      cmd_q <= next_cmd;
      ba_q <= next_ba;
      addr_q <= next_addr;
      dqm_q <= next_dqm;
      oe_n_q <= next_oe_n;
      cke_q <= !pd_hold;
      cs_n_q <= 1'b0;
    end
  end

  // row bookkeeping follows the issued commands
  // precharge of one bank keeps the others open
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_q <= '0;
      cl_q <= MODE_RESET[CL_LSB+:3];
    end else if (next_cmd == CMD_ACT) begin
      open_q[next_ba] <= 1'b1;
      rows[next_ba] <= next_addr;
    end else if (next_cmd == CMD_PRE) begin
      if (next_addr[AP_BIT]) begin
        open_q <= '0;
      end else begin
        open_q[next_ba] <= 1'b0;
      end
    end else if (next_cmd == CMD_LMR) begin
      cl_q <= next_addr[CL_LSB+:3];
    end
  end

  // refresh timer; a new expiry wins over the clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rcnt <= REF_CYC;
      ref_due <= 1'b0;
    end else begin
      rcnt <= rcnt == '0 ? REF_CYC : rcnt - 11'h001;
      if (rcnt == '0) begin
        ref_due <= 1'b1;
      end else if (next_cmd == CMD_REF) begin
        ref_due <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_h <= 1'b0;
      w_h <= 1'b0;
      aw_a <= '0;
      w_d <= '0;
      w_s <= '0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      op_pend <= 1'b0;
      op_r <= OP_NONE;
      addr_r <= '0;
      wdata_r <= '0;
      ctrl_r <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_h <= 1'b1;
        aw_a <= awaddr;
      end
      if (wvalid && wready) begin
        w_h <= 1'b1;
        w_d <= wdata;
        w_s <= wstrb;
      end
      if (go) begin
        op_pend <= 1'b0;
      end
      if (wr_do) begin
        aw_h <= 1'b0;
        w_h <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
        // orders written while busy are dropped
        if (aw_a == REG_CMD && !busy && w_s[0]) begin
          op_pend <= 1'b1;
          op_r <= op_t'(w_d[2:0]);
        end else if (aw_a == REG_ADDR) begin
          addr_r <= merge(addr_r, w_d, w_s);
        end else if (aw_a == REG_WDATA) begin
          wdata_r <= merge(wdata_r, w_d, w_s);
        end else if (aw_a == REG_CTRL) begin
          ctrl_r <= merge(ctrl_r, w_d, w_s);
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
      rdv <= 1'b0;
      rdat_r <= '0;
    end else begin
      if (ar_do) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
      // capture wins over the read-side clear
      if (state == ST_RDW && wcnt == '0) begin
        rdat_r <= link.dq;
        rdv <= 1'b1;
      end else if (ar_do && araddr == REG_RDATA) begin
        rdv <= 1'b0;
      end
    end
  end

  assign link.cke = cke_q;
  assign link.cs_n = cs_n_q;
  assign {link.ras_n, link.cas_n, link.we_n} = cmd_q;
  assign link.ba = ba_q;
  assign link.addr = addr_q;
  assign link.dqm = dqm_q;
  assign link.ctrl_dq = wdata_r;
  assign link.ctrl_dq_oe_n = oe_n_q;
endmodule : sdram_ctrl
`default_nettype wire

// [rtl/sdram_if.sv]
// pin bundle between the sdram controller and the sdram device
`timescale 1ns/10ps
`default_nettype none
interface sdram_if;
  import sdram_pkg::*;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [BW-1:0] ba;
  logic [AW-1:0] addr;
  logic [NBYTE-1:0] dqm;
  logic [DW-1:0] ctrl_dq;
  logic ctrl_dq_oe_n;
  logic [DW-1:0] mem_dq;
  logic [NBYTE-1:0] mem_dq_oe_n;
  logic [DW-1:0] dq;
  // bus resolution per byte; an undriven byte reads as all ones
  for (genvar i = 0; i < NBYTE; i++) begin : g_res
    assign dq[i*8+:8] = !mem_dq_oe_n[i] ? mem_dq[i*8+:8] :
                        (!ctrl_dq_oe_n ? ctrl_dq[i*8+:8] : 8'hFF);
  end
  modport mem (
    input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm, dq,
    output mem_dq, mem_dq_oe_n
  );
  modport ctrl (
    output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dqm,
    output ctrl_dq, ctrl_dq_oe_n,
    input dq
  );
endinterface : sdram_if
`default_nettype wire

// [rtl/sdram_mem.sv]
// four-bank synchronous dram device end
`timescale 1ns/10ps
`default_nettype none
module sdram_mem import sdram_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  sdram_if.mem link,
  output logic power_down,
  output logic [BANKS-1:0] bank_open,
  output logic [AW-1:0] refresh_row,
  output logic misuse
);
  // array of banks by rows by columns
  logic [DW-1:0] mem [0:BANKS*ROWS*COLS-1];
  logic [AW-1:0] mode;
  logic [AW-1:0] row_q [BANKS];
  logic bon;
  logic bwr;
  logic bap;
  logic [BW-1:0] bbank;
  logic [CW-1:0] bstart;
  logic [CW-1:0] bcnt;
  logic [NBYTE-1:0] dqm_d1;
  logic [NBYTE-1:0] dqm_d2;
  logic [CL_MAX-1:0] rv;
  logic [DW-1:0] rd [CL_MAX];
  logic [BANKS-1:0] next_open;
  logic [BANKS-1:0] load_row;
  cmd_t cmd;

  assign cmd = cmd_t'({link.ras_n, link.cas_n, link.we_n});

  // low clock enable freezes the whole device
  wire logic adv = link.cke;
  wire logic take = link.cke && !link.cs_n;
  wire logic is_act = take && cmd == CMD_ACT;
  wire logic is_pre = take && cmd == CMD_PRE;
  wire logic is_rw = take && (cmd == CMD_RD || cmd == CMD_WR);
  wire logic all_idle = bank_open == '0 && !bon;
  // column access only to an opened bank
  wire logic col_cmd = is_rw && bank_open[link.ba];
  wire logic stop = take && cmd == CMD_BST;

  // burst length from the mode word
  wire logic [2:0] blc = mode[BLC_LSB+:3];
  wire logic full = blc == BLC_FULL;
  wire logic [CW-1:0] mask =
    full ? '1 : CW'((9'h001 << blc[1:0]) - 9'h001);
  // interleaved order only for fixed lengths
  wire logic il = mode[BT_BIT] && !full;

  // first column from the command itself
  wire logic [CW-1:0] start = col_cmd ? link.addr[CW-1:0] : bstart;
  wire logic [CW-1:0] cnt = col_cmd ? '0 : bcnt;
  wire logic [CW-1:0] seqc = start + cnt;
  wire logic [CW-1:0] ilc = start ^ cnt;
  wire logic [CW-1:0] beat_col =
    (start & ~mask) | ((il ? ilc : seqc) & mask);
  wire logic [BW-1:0] beat_bank = col_cmd ? link.ba : bbank;
  wire logic beat_wr = col_cmd ? cmd == CMD_WR : bwr;
  // a new column command preempts the running burst
  wire logic beat = col_cmd || (bon && adv && !stop);
  // full-row bursts wrap until stopped
  wire logic last = !full && cnt == mask;
  // auto precharge once the final beat is done
  wire logic ap_close =
    beat && last && (col_cmd ? link.addr[AP_BIT] : bap);
  wire logic [IW-1:0] idx = {beat_bank, row_q[beat_bank], beat_col};
  wire logic [DW-1:0] rword = mem[idx];
  logic [DW-1:0] wword;

  // write mask acts in the same cycle
  for (genvar i = 0; i < NBYTE; i++) begin : g_wmask
    assign wword[i*8+:8] =
      link.dqm[i] ? rword[i*8+:8] : link.dq[i*8+:8];
  end

  // each bank opens and closes on its own
  for (genvar b = 0; b < BANKS; b++) begin : g_bank
    wire logic hit = link.ba == BW'(b);
    // bank lines pick the bank, address the row
    assign load_row[b] = is_act && hit && !bank_open[b];
    // bit 10 selects all banks or one
    wire logic pre_hit = is_pre && (hit || link.addr[AP_BIT]);
    wire logic ap_hit = ap_close && beat_bank == BW'(b);
    assign next_open[b] =
      load_row[b] ? 1'b1 : ((pre_hit || ap_hit) ? 1'b0 : bank_open[b]);
  end

  // every input taken on the rising edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bank_open <= '0;
    end else if (adv) begin
      bank_open <= next_open;
    end
  end

  // row addresses hold no control meaning, so they are not reset
  always_ff @(posedge aclk) begin
    for (int b = 0; b < BANKS; b++) begin
      if (adv && load_row[b]) begin
        row_q[b] <= link.addr;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (adv && beat && beat_wr) begin
      mem[idx] <= wword;
    end
  end

  // burst sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bon <= 1'b0;
      bwr <= 1'b0;
      bap <= 1'b0;
      bbank <= '0;
      bstart <= '0;
      bcnt <= '0;
    end else if (col_cmd) begin
      bon <= !last;
      bwr <= cmd == CMD_WR;
      bap <= link.addr[AP_BIT];
      bbank <= link.ba;
      bstart <= link.addr[CW-1:0];
      bcnt <= CW'(1);
    end else if (adv && stop) begin
      bon <= 1'b0;
    end else if (beat) begin
      bon <= !last;
      bcnt <= bcnt + CW'(1);
    end
  end

  // mode load and refresh are only honoured with every bank idle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MODE_RESET;
      refresh_row <= '0;
    end else if (take && all_idle && cmd == CMD_LMR) begin
      mode <= link.addr;
    end else if (take && all_idle && cmd == CMD_REF) begin
      // auto refresh advances the internal row counter
      refresh_row <= refresh_row + AW'(1);
    end
  end

  // power-down whenever the clock enable is low and no burst is running
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      power_down <= 1'b0;
    end else begin
      power_down <= !link.cke && !bon;
    end
  end

  // sticky flag for column access to a closed bank or a reopen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      misuse <= 1'b0;
    end else if ((is_rw && !col_cmd) ||
                 (is_act && bank_open[link.ba])) begin
      misuse <= 1'b1;
    end
  end

  // read data pipeline, one stage per cycle of read latency
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv <= '0;
      dqm_d1 <= '1;
      dqm_d2 <= '1;
    end else if (adv) begin
      rv <= {rv[CL_MAX-2:0], beat && !beat_wr};
      // read mask delayed by two clocks
      dqm_d1 <= link.dqm;
      dqm_d2 <= dqm_d1;
    end
  end

  always_ff @(posedge aclk) begin
    if (adv) begin
      rd[0] <= rword;
      for (int s = 1; s < CL_MAX; s++) begin
        rd[s] <= rd[s-1];
      end
    end
  end

  // latency codes above the deepest stage clamp to it
  wire logic [2:0] cl = mode[CL_LSB+:3];
  wire logic [1:0] sel =
    (cl >= 3'h3) ? 2'h2 : ((cl == 3'h2) ? 2'h1 : 2'h0);

  assign link.mem_dq = rd[sel];
  for (genvar i = 0; i < NBYTE; i++) begin : g_oe
    assign link.mem_dq_oe_n[i] = !rv[sel] || dqm_d2[i];
  end
endmodule : sdram_mem
`default_nettype wire

// [rtl/sdram_pkg.sv]
// shared constants for the sdram device model and its controller
package sdram_pkg;
  localparam int BANKS = 4;
  localparam int ROWS = 4096;
  localparam int COLS = 256;
  localparam int DW = 32;
  localparam int BW = 2;
  localparam int AW = 12;
  localparam int CW = 8;
  localparam int NBYTE = 4;
  localparam int IW = BW + AW + CW;
  localparam int CL_MAX = 3;
  localparam int AP_BIT = 10;
  // mode word: burst length code, burst order, read latency
  localparam int BLC_LSB = 0;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam logic [2:0] BLC_FULL = 3'h7;
  localparam logic [AW-1:0] MODE_RESET = 12'h030;
  // command code is {ras_n, cas_n, we_n} with cs_n low
  typedef enum logic [2:0] {
    CMD_LMR = 3'b000, CMD_REF = 3'b001, CMD_PRE = 3'b010,
    CMD_ACT = 3'b011, CMD_WR = 3'b100, CMD_RD = 3'b101,
    CMD_BST = 3'b110, CMD_NOP = 3'b111
  } cmd_t;
  typedef enum logic [2:0] {
    OP_NONE = 3'h0, OP_READ = 3'h1, OP_WRITE = 3'h2,
    OP_MODE = 3'h3, OP_STOP = 3'h4, OP_PRE = 3'h5
  } op_t;
  // controller register map
  localparam logic [7:0] REG_CMD = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  localparam int ROW_LSB = 8;
  localparam int BANK_LSB = 20;
  localparam int ALL_BIT = 22;
  localparam int PD_BIT = 0;
  localparam int MASK_LSB = 4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // timing
  localparam int CLK_NS = 10;
  localparam int TRCD_NS = 20;
  localparam int TRP_NS = 20;
  localparam int TRFC_NS = 70;
  localparam int TWR_NS = 20;
  localparam int TMRD_NS = 20;
  localparam int REF_STD_MS = 64;
  localparam int REF_EXT_MS = 16;
  localparam int REF_ROWS = 4096;
  localparam int TRCD_CYC = (TRCD_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRP_CYC = (TRP_NS + CLK_NS - 1) / CLK_NS;
  localparam int TRFC_CYC = (TRFC_NS + CLK_NS - 1) / CLK_NS;
  localparam int TWR_CYC = (TWR_NS + CLK_NS - 1) / CLK_NS;
  localparam int TMRD_CYC = (TMRD_NS + CLK_NS - 1) / CLK_NS;
  localparam int REF_STD_CYC = REF_STD_MS * 1000000 / REF_ROWS / CLK_NS;
  localparam int REF_EXT_CYC = REF_EXT_MS * 1000000 / REF_ROWS / CLK_NS;
endpackage : sdram_pkg

// [verification/sdram_link_assertions.sv]
// concurrent checks on the sdram pin link
`timescale 1ns/10ps
`default_nettype none
module sdram_link_assertions import sdram_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [BW-1:0] ba,
  input wire logic [AW-1:0] addr,
  input wire logic [NBYTE-1:0] dqm,
  input wire logic ctrl_dq_oe_n,
  input wire logic [NBYTE-1:0] mem_dq_oe_n
);
  // slack for an op in flight; assumes the extended grade
  localparam int LIM = REF_EXT_CYC + 40;
  wire logic [2:0] c = {ras_n, cas_n, we_n};
  wire logic go = cke && !cs_n;
  wire logic act = go && c == CMD_ACT;
  wire logic rd = go && c == CMD_RD;
  wire logic col = go && (c == CMD_RD || c == CMD_WR);
  wire logic pre = go && c == CMD_PRE;
  wire logic rfs = go && c == CMD_REF;
  logic [BANKS-1:0] opn;
  logic [BANKS-1:0] next_opn;
  logic [15:0] gap;
  // auto precharge closes at once here: weakens the reopen and refresh checks, tightens the column check
  always_comb begin
    next_opn = opn;
    if (act) next_opn[ba] = 1'b1;
    if (pre || (col && addr[AP_BIT])) next_opn[ba] = 1'b0;
    if (pre && addr[AP_BIT]) next_opn = '0;
  end
  always_ff @(posedge aclk) begin
    opn <= aresetn ? next_opn : '0;
    gap <= (!aresetn || rfs) ? 16'h0 : gap + 16'h1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_rd; rd ##1 dqm == 4'h0; endsequence
  a_read_latency: assert property (s_rd |-> ##2 mem_dq_oe_n == 4'h0)
    else $error("read data late");
  a_no_fight: assert property (!ctrl_dq_oe_n |-> &mem_dq_oe_n)
    else $error("bus contention");
  a_open_first: assert property (col |-> opn[ba])
    else $error("column to closed bank");
  a_reopen_closed: assert property (act |-> !opn[ba])
    else $error("open on open bank");
  a_act_gap: assert property (act |=> !col [*2])
    else $error("column too soon");
  a_pre_gap: assert property (pre |=> !(act || rfs) [*2])
    else $error("open too soon");
  a_ref_gap: assert property (rfs |=> !(act || rfs) [*7])
    else $error("refresh too close");
  a_ref_closed: assert property (rfs |-> opn == '0)
    else $error("refresh with open row");
  a_ref_due: assert property (gap <= LIM)
    else $error("refresh overdue");
endmodule : sdram_link_assertions
`default_nettype wire

// [verification/test_quad_bank_sdram_core.sv]
// bench joining the sdram controller and device
`timescale 1ns/10ps
`default_nettype none
module test_quad_bank_sdram_core import sdram_pkg::*;;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  wire logic awready, wready, bvalid, arready, rvalid, pd, mis;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [BANKS-1:0] bo;
  wire logic [AW-1:0] rfr;
  integer seed = 38896;
  int fails = 0;
  int tests_run = 0;
  logic [31:0] mdl [int];
  logic [31:0] v;
  logic [1:0] r;
  logic [21:0] loc [8];
  sdram_if link ();
  sdram_ctrl #(.extended_temperature_grade(1'b1)) u_sdram_ctrl (.aclk,
    .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb(4'hF), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .rvalid, .rready, .rdata, .rresp, .link(link.ctrl));
  sdram_mem u_sdram_mem (.aclk, .aresetn, .link(link.mem),
    .power_down(pd), .bank_open(bo), .refresh_row(rfr), .misuse(mis));
  sdram_link_assertions u_sdram_link_assertions (.aclk, .aresetn,
    .cke(link.cke), .cs_n(link.cs_n), .ras_n(link.ras_n),
    .cas_n(link.cas_n), .we_n(link.we_n), .ba(link.ba),
    .addr(link.addr), .dqm(link.dqm), .ctrl_dq_oe_n(link.ctrl_dq_oe_n),
    .mem_dq_oe_n(link.mem_dq_oe_n));
  initial forever #5 aclk = ~aclk;
  // about 2000 cycles expected; the limit leaves wide margin
  initial begin
    #200000;
    fails++;
    results();
  end
  task automatic chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : results
  function automatic logic [31:0] merge(input logic [31:0] o, n,
      input logic [3:0] m);
    for (int b = 0; b < 4; b++) if (!m[b]) o[b*8+:8] = n[b*8+:8];
    return o;
  endfunction : merge
  // ready is sampled mid-cycle so the edge decision never races
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      v = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
    end
  endtask : rd
  task automatic op(input logic [2:0] c, input logic [22:0] a);
    int n;
    logic [AW-1:0] rr;
    wr(REG_ADDR, {9'h0, a});
    n = 0;
    v = 32'h1;
    // an order that meets a refresh is dropped, so it is sent again
    while (v[0] && n < 300) begin
      rr = rfr;
      wr(REG_CMD, {29'h0, c});
      v = 32'h1;
      while (v[0] && n < 300) begin
        rd(REG_STATUS);
        n++;
      end
      if (rfr != rr) v[0] = 1'b1;
    end
    chk("idle", 32'h0, {31'h0, v[0]});
  endtask : op
  task automatic wrw(input int i, input logic [31:0] d);
    wr(REG_WDATA, d);
    op(OP_WRITE, {1'b0, loc[i]});
  endtask : wrw
  task automatic rchk(input int i);
    op(OP_READ, {1'b0, loc[i]});
    chk("rdv", 32'h1, {31'h0, v[1]});
    rd(REG_RDATA);
    chk("word", mdl[loc[i]], v);
  endtask : rchk
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(REG_STATUS);
    chk("status", 32'h0, v);
    wr(8'h40, 32'h1);
    chk("bresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    rd(8'h40);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    chk("rdata", 32'h0, v);
    $display("test registers done");
    loc[0] = 22'h0;
    loc[1] = {2'h0, 12'h001, 8'hFF};
    loc[2] = {2'h3, 12'hFFF, 8'hFF};
    loc[3] = {2'h1, 12'h800, 8'h80};
    for (int i = 4; i < 8; i++) loc[i] = 22'($random(seed));
    for (int i = 0; i < 8; i++) begin
      mdl[loc[i]] = $random(seed);
      wrw(i, mdl[loc[i]]);
    end
    for (int i = 0; i < 8; i++) rchk(i);
    $display("test banks done");
    wr(REG_CTRL, 32'hA0);
    v = $random(seed);
    mdl[loc[0]] = merge(mdl[loc[0]], v, 4'hA);
    wrw(0, v);
    wr(REG_CTRL, 32'h0);
    rchk(0);
    $display("test mask done");
    op(OP_PRE, 23'h400000);
    chk("banks", 32'h0, {28'h0, bo});
    op(OP_MODE, {11'h0, MODE_RESET});
    op(OP_STOP, 23'h0);
    rchk(1);
    rchk(2);
    $display("test precharge done");
    // start just after a refresh so none falls inside the sleep
    v[11:0] = rfr;
    while (rfr == v[11:0]) @(negedge aclk);
    @(posedge aclk);
    wr(REG_CTRL, 32'h1);
    repeat (20) @(posedge aclk);
    rd(REG_STATUS);
    chk("cke low", 32'h1, {31'h0, v[2]});
    chk("pd", 32'h1, {31'h0, pd});
    wr(REG_CTRL, 32'h0);
    repeat (10) @(posedge aclk);
    rd(REG_STATUS);
    chk("cke high", 32'h0, {31'h0, v[2]});
    $display("test power done");
    v[11:0] = rfr;
    repeat (900) @(posedge aclk);
    chk("refreshed", 32'h1, {31'h0, rfr != v[11:0]});
    for (int i = 0; i < 8; i++) rchk(i);
    chk("misuse", 32'h0, {31'h0, mis});
    $display("test refresh done");
    results();
  end
endmodule : test_quad_bank_sdram_core
`default_nettype wire
